// ### mdv_pkg.sv
// Purpose: Constants for the manual digital volume block
// Assumes: 200 MHz clock, 48 kHz sample rate
// Notes: Gain codes are 8 bit, 0.375 dB per code
package mdv_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_IN_GAIN = 8'h04;
    localparam logic [7:0] A_OUT_GAIN = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam int B_REC_EN = 0;
    localparam int B_PLAY_EN = 1;
    localparam int B_SRC_ADC = 2;
    localparam int B_FPOW = 3;
    localparam int B_DPOW = 4;
    localparam int B_IN_LINK = 5;
    localparam int B_OUT_LINK = 6;
    localparam int B_RAMP_SEL = 7;
    localparam int B_ZC_LO = 8;
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam logic [7:0] CODE_MAX = 8'hF1;
    localparam logic [7:0] CODE_MIN = 8'h05;
    localparam logic [7:0] IN_RST = 8'hE1;
    localparam logic [7:0] OUT_RST = 8'h91;
    localparam logic signed [8:0] POS_0DB = 9'h091;
    localparam logic signed [8:0] POS_FLOOR = 9'h1D1;
    localparam logic [9:0] MUTE_IN_FS = 10'h0EC;
    localparam logic [9:0] MUTE_OUT_FS = 10'h0D0;
    localparam logic [1:0] SLOW_LAST = 2'h3;
    localparam int CLK_HZ = 200000000;
    localparam int FS_HZ = 48000;
    localparam int FS_DIV = CLK_HZ / FS_HZ;

    // Widest select needs 1024 ticks, one bit more than the tail counter
    function automatic logic [10:0] zc_limit(input logic [1:0] sel);
        zc_limit = 11'h080 << sel;
    endfunction : zc_limit

    function automatic logic [16:0] mant(input logic [3:0] k);
        unique case (k)
            4'h0: mant = 17'h08000;
            4'h1: mant = 17'h085AB;
            4'h2: mant = 17'h08B96;
            4'h3: mant = 17'h091C4;
            4'h4: mant = 17'h09838;
            4'h5: mant = 17'h09EF5;
            4'h6: mant = 17'h0A5FF;
            4'h7: mant = 17'h0AD58;
            4'h8: mant = 17'h0B505;
            4'h9: mant = 17'h0BD09;
            4'hA: mant = 17'h0C567;
            4'hB: mant = 17'h0CE25;
            4'hC: mant = 17'h0D745;
            4'hD: mant = 17'h0E0CD;
            4'hE: mant = 17'h0EAC1;
            4'hF: mant = 17'h0F525;
        endcase
    endfunction : mant
endpackage : mdv_pkg

// ### mdv_volume.sv
// Purpose: Manual input/output digital volume with soft ramp and mute
// Assumes: One stereo sample pair per word on the stream
// Notes: Ramp advances on an fs enable from a clock divider
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module mdv_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic wr;
    logic rd;
    if (D < 2 || (1 << AW) != D)
    begin : g_bad_depth
        $error("depth must be power of 2");
    end
    assign wr = in_valid_i && in_ready_o;
    assign rd = out_valid_o && out_ready_i;
    assign out_data_o = mem[rp];
    always_comb
    begin
        next_cnt = cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
    always_ff @(posedge clk_i)
    begin
        if (wr) mem[wp] <= in_data_i;
    end
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            wp <= wp + AW'(wr);
            rp <= rp + AW'(rd);
            cnt <= next_cnt;
            // Registered flags keep ready and valid glitch free
            in_ready_o <= next_cnt != (AW+1)'(D);
            out_valid_o <= next_cnt != '0;
        end
    end
endmodule : mdv_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// RL1: Input manual when record control off, source ADC
// RL2: Host programs control in manual mode
// RL3: Input code F1H=+36dB, 0.375dB steps, mute below 05H
// RL4: Input link makes left code set both
// RL5: Gain ramps; full span 236 or 944 fs
// RL6: Input mute ramps to -72dB over 236 fs
// RL7: Gains written unpowered start on power up
// RL8: Output manual when powered, play control off
// RL9: Output code map same, reset 0dB
// RL10: Output link makes left code set both
// RL11: Zero crossings detected per channel
// RL12: New output value at crossing or timeout
// RL13: Output shares ramp select; mute ramp 208 fs
// RL14: One code per sample, or per four
module mdv_volume #(
    parameter int DW = 16,
    parameter int DEPTH = 8,
    parameter int FS_DIV = mdv_pkg::FS_DIV
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic s_valid_i,
    input wire logic [DW-1:0] s_left_i,
    input wire logic [DW-1:0] s_right_i,
    output logic s_ready_o,
    output logic m_valid_o,
    output logic [DW-1:0] m_left_o,
    output logic [DW-1:0] m_right_o,
    input wire logic m_ready_i
);
    if (DW < 8 || FS_DIV < 2)
    begin : g_bad_param
        $error("bad parameters");
    end
    logic [9:0] ctrl;
    logic [15:0] in_gain;
    logic [15:0] out_gain;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] fs_cnt;
    logic tick;
    logic [1:0] div4;
    logic in_act;
    logic out_act;
    logic act;
    logic step_ok;
    logic [7:0] pend [2];
    logic [7:0] app [2];
    logic [7:0] tgt [2];
    logic signed [8:0] cur [2];
    logic muted [2];
    logic [9:0] mcnt [2];
    logic [10:0] zto [2];
    logic [9:0] mlim;
    logic prev_neg [2];
    logic zc [2];
    logic f_valid;
    logic f_ready;
    logic [2*DW-1:0] f_data;
    logic signed [DW-1:0] f_s [2];
    logic take;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= '0;
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end
        else if (hready_i)
        begin
            wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr <= haddr_i[7:0];
            hrdata_o <= '0;
            if (hsel_i && htrans_i[1] && !hwrite_i)
            begin
                unique case (haddr_i[7:0])
                    mdv_pkg::A_CTRL: hrdata_o <= {22'h0, ctrl};
                    mdv_pkg::A_IN_GAIN: hrdata_o <= {16'h0, in_gain};
                    mdv_pkg::A_OUT_GAIN: hrdata_o <= {16'h0, out_gain};
                    mdv_pkg::A_STATUS: hrdata_o <= {12'h0, out_act, in_act,
                        muted[1], muted[0], cur[1][7:0], cur[0][7:0]};
                    default: hrdata_o <= '0;
                endcase
            end
        end
    end

    // Gains are plain storage; written values wait for power (RL7)
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl <= mdv_pkg::CTRL_RST;
            in_gain <= {mdv_pkg::IN_RST, mdv_pkg::IN_RST}; // RL3
            out_gain <= {mdv_pkg::OUT_RST, mdv_pkg::OUT_RST}; // RL9
        end
        else if (wr_pend)
        begin
            if (wr_addr == mdv_pkg::A_CTRL) ctrl <= hwdata_i[9:0];
            if (wr_addr == mdv_pkg::A_IN_GAIN) in_gain <= hwdata_i[15:0];
            if (wr_addr == mdv_pkg::A_OUT_GAIN) out_gain <= hwdata_i[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample rate enable and mode decode
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fs_cnt <= '0;
            tick <= 1'b0;
            div4 <= '0;
        end
        else
        begin
            tick <= fs_cnt == 32'(FS_DIV - 1);
            fs_cnt <= (fs_cnt == 32'(FS_DIV - 1)) ? '0 : fs_cnt + 32'h1;
            if (tick) div4 <= div4 + 2'h1;
        end
    end

    assign in_act = !ctrl[mdv_pkg::B_REC_EN] && ctrl[mdv_pkg::B_SRC_ADC]
        && ctrl[mdv_pkg::B_FPOW]; // RL1 RL7
    assign out_act = !ctrl[mdv_pkg::B_PLAY_EN] && ctrl[mdv_pkg::B_FPOW]
        && ctrl[mdv_pkg::B_DPOW] && !ctrl[mdv_pkg::B_SRC_ADC]; // RL8
    assign act = in_act || out_act;
    assign step_ok = !ctrl[mdv_pkg::B_RAMP_SEL]
        || div4 == mdv_pkg::SLOW_LAST; // RL14
    assign mlim = in_act ? mdv_pkg::MUTE_IN_FS : mdv_pkg::MUTE_OUT_FS; // RL6 RL13
    assign pend[0] = out_gain[7:0];
    assign pend[1] = ctrl[mdv_pkg::B_OUT_LINK] ? out_gain[7:0]
        : out_gain[15:8]; // RL10
    // Source select alone picks the codes, so held input codes track unpowered
    assign tgt[0] = ctrl[mdv_pkg::B_SRC_ADC] ? in_gain[7:0] : app[0]; // RL7
    assign tgt[1] = !ctrl[mdv_pkg::B_SRC_ADC] ? app[1] :
        ctrl[mdv_pkg::B_IN_LINK] ? in_gain[7:0] : in_gain[15:8]; // RL4
    assign f_ready = !m_valid_o || m_ready_i;
    assign take = f_valid && f_ready;
    assign f_s[0] = f_data[DW-1:0];
    assign f_s[1] = f_data[2*DW-1:DW];

    ////////////////////////////////////////////////////////////////////////////
    // Soft ramp per channel; mute goes through a floor at -72 dB
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int c = 0; c < 2; c++)
            begin
                cur[c] <= mdv_pkg::POS_0DB;
                muted[c] <= 1'b0;
                mcnt[c] <= '0;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (!act)
                begin
                    // Resume with the held codes once powered
                    cur[c] <= (tgt[c] < mdv_pkg::CODE_MIN) ? mdv_pkg::POS_FLOOR
                        : signed'({1'b0, tgt[c]}); // RL7
                    muted[c] <= tgt[c] < mdv_pkg::CODE_MIN;
                    mcnt[c] <= '0;
                end
                else if (tick && tgt[c] < mdv_pkg::CODE_MIN)
                begin
                    if (cur[c] > signed'({1'b0, mdv_pkg::CODE_MIN}))
                    begin
                        if (step_ok) cur[c] <= cur[c] - 9'sh001; // RL5
                    end
                    else
                    begin
                        // Fixed-length tail, then hard mute
                        if (cur[c] > mdv_pkg::POS_FLOOR)
                            cur[c] <= cur[c] - 9'sh001;
                        if (mcnt[c] == mlim - 10'h1) muted[c] <= 1'b1; // RL6 RL13
                        else if (!muted[c]) mcnt[c] <= mcnt[c] + 10'h1;
                    end
                end
                else if (tick)
                begin
                    muted[c] <= 1'b0;
                    mcnt[c] <= '0;
                    if (step_ok && cur[c] < signed'({1'b0, tgt[c]}))
                        cur[c] <= cur[c] + 9'sh001; // RL5 RL14
                    else if (step_ok && cur[c] > signed'({1'b0, tgt[c]}))
                        cur[c] <= cur[c] - 9'sh001; // RL5 RL14
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output path: apply new code at zero crossing or timeout
    always_comb
    begin
        for (int c = 0; c < 2; c++)
            zc[c] = (f_s[c][DW-1] != prev_neg[c]) || f_s[c] == '0; // RL11
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int c = 0; c < 2; c++)
            begin
                app[c] <= mdv_pkg::OUT_RST;
                zto[c] <= '0;
                prev_neg[c] <= 1'b0;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (take) prev_neg[c] <= f_s[c][DW-1];
                if (!out_act || app[c] == pend[c])
                begin
                    app[c] <= pend[c];
                    zto[c] <= '0;
                end
                else if ((take && zc[c]) || zto[c] ==
                    mdv_pkg::zc_limit(ctrl[mdv_pkg::B_ZC_LO +: 2]))
                begin
                    app[c] <= pend[c]; // RL12
                    zto[c] <= '0;
                end
                else if (tick) zto[c] <= zto[c] + 11'h1; // RL12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain multiply: 16 mantissas per 6 dB octave, then shift
    function automatic logic [DW-1:0] apply_gain(input logic signed [DW-1:0] s,
        input logic signed [8:0] p, input logic mu);
        logic signed [8:0] d;
        logic signed [DW+17:0] prod;
        logic signed [DW+17:0] lim;
        d = p - mdv_pkg::POS_0DB;
        prod = s * signed'({1'b0, mdv_pkg::mant(d[3:0])});
        prod = prod >>> (5'd15 - 5'(d >>> 4)); // RL3 RL9
        lim = (DW+18)'({1'b0, {(DW-1){1'b1}}});
        if (mu) apply_gain = '0;
        else if (prod > lim) apply_gain = lim[DW-1:0];
        else if (prod < -lim) apply_gain = DW'(-lim);
        else apply_gain = prod[DW-1:0];
    endfunction : apply_gain

    mdv_fifo #(.W(2*DW), .D(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(s_valid_i),
        .in_data_i({s_right_i, s_left_i}),
        .in_ready_o(s_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_ready)
    );

    // Idle modes pass zero data so nothing leaks from an unset path
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            m_valid_o <= 1'b0;
            m_left_o <= '0;
            m_right_o <= '0;
        end
        else if (take)
        begin
            m_valid_o <= 1'b1;
            m_left_o <= act ? apply_gain(f_s[0], cur[0], muted[0]) : '0; // RL1 RL8
            m_right_o <= act ? apply_gain(f_s[1], cur[1], muted[1]) : '0;
        end
        else if (m_ready_i) m_valid_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_idle_zero: assert property ( // RL1 RL8
        take && !act |=> m_left_o == '0 && m_right_o == '0)
        else $error("idle path not zero");
    a_unity_gain: assert property ( // RL3 RL9
        take && act && cur[0] == mdv_pkg::POS_0DB && !muted[0]
        |=> m_left_o == $past(f_s[0]))
        else $error("0dB not unity");
    a_in_link: assert property ( // RL4
        in_act && ctrl[mdv_pkg::B_IN_LINK] |-> tgt[1] == tgt[0])
        else $error("input link broken");
    a_out_link: assert property ( // RL10
        ctrl[mdv_pkg::B_OUT_LINK] |-> pend[1] == pend[0])
        else $error("output link broken");
    a_ramp_tick: assert property ( // RL5
        act && $past(act) && !$past(tick) |-> $stable(cur[0]))
        else $error("ramp moved off tick");
    a_slow_hold: assert property ( // RL14
        act && tick && ctrl[mdv_pkg::B_RAMP_SEL]
        && div4 != mdv_pkg::SLOW_LAST && cur[0] > 9'sh005 ##1 act
        |-> $stable(cur[0]))
        else $error("slow ramp too fast");
    a_mute_len: assert property ( // RL6 RL13
        act && $past(act) && $rose(muted[0])
        |-> $past(mcnt[0]) == mlim - 10'h1)
        else $error("mute tail length");
    a_apply_cause: assert property ( // RL11 RL12
        out_act && $past(out_act) && $changed(app[0])
        && $past(app[0] != pend[0])
        |-> $past(take && zc[0])
        || $past(zto[0]) == mdv_pkg::zc_limit($past(ctrl[9:8])))
        else $error("output applied without cause");
    a_held_gain: assert property ( // RL7
        !act && ctrl[mdv_pkg::B_SRC_ADC]
        && in_gain[7:0] >= mdv_pkg::CODE_MIN
        ##1 !act && $stable(in_gain) && ctrl[mdv_pkg::B_SRC_ADC]
        |-> cur[0] == signed'({1'b0, in_gain[7:0]}))
        else $error("held gain");
    c_mute_done: cover property (act && $rose(muted[0]));
    c_zc_timeout: cover property (out_act && zto[0] != '0 ##1 zto[0] == '0);
    c_ramp_top: cover property (in_act && cur[0] == 9'sh0F1);
endmodule : mdv_volume

// ### mdv_audio_model.sv
// Purpose: Audio sample source and sink at the stream ports
// Assumes: Left and right travel together, one pair per beat
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ps
module mdv_audio_model #(
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic stall_i,
    output logic s_valid_o,
    output logic [DW-1:0] s_left_o,
    output logic [DW-1:0] s_right_o,
    input wire logic s_ready_i,
    input wire logic m_valid_i,
    input wire logic [DW-1:0] m_left_i,
    input wire logic [DW-1:0] m_right_i,
    output logic m_ready_o
);
    logic [2*DW-1:0] got[$];

    initial
    begin
        s_valid_o = 1'b0;
        s_left_o = '0;
        s_right_o = '0;
        m_ready_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Offer one pair; held until taken or the wait runs out
    task automatic send(input logic [DW-1:0] l, input logic [DW-1:0] r,
                        input int tmo, output bit taken);
        logic rdy;
        s_valid_o <= 1'b1;
        s_left_o <= l;
        s_right_o <= r;
        taken = 1'b0;
        for (int i = 0; i < tmo && !taken; i++)
        begin
            @(negedge clk_i);
            rdy = s_ready_i;
            @(posedge clk_i);
            taken = (rdy === 1'b1);
        end
    endtask : send

    // Stale data would hide a design that samples without valid
    task automatic idle();
        s_valid_o <= 1'b0;
        s_left_o <= ~s_left_o;
        s_right_o <= ~s_right_o;
    endtask : idle

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        if (m_valid_i === 1'b1 && m_ready_o === 1'b1)
            got.push_back({m_left_i, m_right_i});
        m_ready_o <= !stall_i;
    end
endmodule : mdv_audio_model

// ### mdv_volume_tb_top.sv
// Purpose: Self-checking bench for the manual digital volume
// Assumes: fs tick every FSD clocks to keep ramps short
// Notes: Bus data sampled just before the closing edge
`timescale 1ns/1ps
`define CHK(a, b) chk(32'(a), 32'(b))
module mdv_volume_tb_top;
    localparam int FSD = 4;
    localparam logic [31:0] C_IN = 32'h0000000C;
    localparam logic [31:0] C_OUT = 32'h00000018;
    logic clk_i;
    logic nrst_i;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic s_valid;
    logic [15:0] s_left;
    logic [15:0] s_right;
    logic s_ready;
    logic m_valid;
    logic [15:0] m_left;
    logic [15:0] m_right;
    logic m_ready;
    logic stall;
    int cyc;
    int mismatches;
    int checks_done;

    mdv_volume #(.DW(16), .DEPTH(8), .FS_DIV(FSD)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .s_valid_i(s_valid),
        .s_left_i(s_left), .s_right_i(s_right), .s_ready_o(s_ready),
        .m_valid_o(m_valid), .m_left_o(m_left), .m_right_o(m_right),
        .m_ready_i(m_ready));

    mdv_audio_model #(.DW(16)) u_mod (
        .clk_i(clk_i), .stall_i(stall), .s_valid_o(s_valid),
        .s_left_o(s_left), .s_right_o(s_right), .s_ready_i(s_ready),
        .m_valid_i(m_valid), .m_left_i(m_left), .m_right_i(m_right),
        .m_ready_o(m_ready));

    always #2.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // Budget is over thirty times the longest mute tail (236 ticks of FSD clocks, 944 cycles)
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////////
    task automatic edge_rdy(output logic r, output logic [31:0] d);
        @(negedge clk_i);
        r = hreadyout;
        d = hrdata;
        @(posedge clk_i);
    endtask : edge_rdy

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic r;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do edge_rdy(r, rd);
        while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do edge_rdy(r, rd);
        while (r !== 1'b1);
    endtask : ahb

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        ahb(1'b0, a, 32'h00000000, d);
    endtask : reg_rd

    // Reads status until the masked value shows or the limit runs out
    task automatic poll(input logic [31:0] m, input logic [31:0] v,
                        input int lim, output int n);
        logic [31:0] d;
        int t0;
        t0 = cyc;
        do reg_rd(mdv_pkg::A_STATUS, d);
        while ((d & m) !== v && cyc - t0 < lim);
        n = cyc - t0;
        `CHK(d & m, v);
    endtask : poll

    task automatic xfer(input logic [15:0] l, input logic [15:0] r,
                        output logic [31:0] o);
        bit tk;
        u_mod.send(l, r, 50, tk);
        u_mod.idle();
        for (int i = 0; i < 40 && u_mod.got.size() == 0; i++)
            @(posedge clk_i);
        o = (u_mod.got.size() > 0) ? u_mod.got.pop_front() : 'x;
    endtask : xfer

    task automatic mute_chk(input int ticks);
        int n;
        logic [31:0] o;
        poll(32'h000000FF, 32'h00000005, 1000, n);
        poll(32'h00030000, 32'h00030000, ticks * FSD + 40, n);
        `CHK(n inside {[ticks * FSD - 8:ticks * FSD + 12]}, 1);
        xfer(16'h0300, 16'h0300, o);
        `CHK(o, 0);
    endtask : mute_chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        reg_rd(mdv_pkg::A_CTRL, d);
        `CHK(d[9:0], mdv_pkg::CTRL_RST);
        reg_rd(mdv_pkg::A_IN_GAIN, d);
        `CHK(d[15:0], {mdv_pkg::IN_RST, mdv_pkg::IN_RST});
        reg_rd(mdv_pkg::A_OUT_GAIN, d);
        `CHK(d[15:0], {mdv_pkg::OUT_RST, mdv_pkg::OUT_RST});
        reg_rd(mdv_pkg::A_STATUS, d);
        `CHK(d, {16'h0000, mdv_pkg::OUT_RST, mdv_pkg::OUT_RST});
        `CHK(hresp, 1'b0);
        reg_wr(8'h10, 32'hFFFFFFFF);
        reg_rd(8'h10, d);
        `CHK(d, 0);
    endtask : t_reset

    task automatic t_power();
        int n;
        logic [31:0] d;
        reg_wr(mdv_pkg::A_CTRL, 32'h00000004);
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009193);
        reg_wr(mdv_pkg::A_CTRL, C_IN);
        reg_rd(mdv_pkg::A_STATUS, d);
        `CHK(d[19:18], 2'h1);
        `CHK(d[15:0], 16'h9193);
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009191);
        poll(32'h0000FFFF, 32'h00009191, 200, n);
        xfer(16'h1234, 16'hEDCC, d);
        `CHK(d, 32'h1234EDCC);
        reg_wr(mdv_pkg::A_CTRL, C_IN | 32'h1);
        reg_rd(mdv_pkg::A_STATUS, d);
        `CHK(d[18], 1'b0);
        xfer(16'h1234, 16'hEDCC, d);
        `CHK(d, 0);
        reg_wr(mdv_pkg::A_CTRL, C_IN);
    endtask : t_power

    task automatic t_fifo();
        int n;
        bit tk;
        n = 0;
        tk = 1'b1;
        stall <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 12 && tk; i++)
        begin
            u_mod.send(16'h0100 + 16'(i), 16'h0100, 3, tk);
            n += int'(tk);
        end
        u_mod.idle();
        `CHK(n inside {[8:10]}, 1);
        stall <= 1'b0;
        repeat (40) @(posedge clk_i);
        `CHK(u_mod.got.size(), n);
        `CHK(u_mod.got[0], 32'h01000100);
        u_mod.got.delete();
    endtask : t_fifo

    task automatic t_ramp();
        int n;
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009595);
        poll(32'h0000FFFF, 32'h00009595, 200, n);
        `CHK(n inside {[3 * FSD:4 * FSD + 8]}, 1);
        reg_wr(mdv_pkg::A_CTRL, C_IN | 32'h80);
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009191);
        poll(32'h0000FFFF, 32'h00009191, 400, n);
        `CHK(n inside {[12 * FSD:16 * FSD + 8]}, 1);
    endtask : t_ramp

    task automatic t_link();
        int n;
        reg_wr(mdv_pkg::A_CTRL, C_IN);
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009199);
        poll(32'h0000FFFF, 32'h00009199, 200, n);
        reg_wr(mdv_pkg::A_CTRL, C_IN | 32'h20);
        poll(32'h0000FFFF, 32'h00009999, 200, n);
    endtask : t_link

    task automatic t_out();
        int n;
        logic [31:0] o;
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00009999);
        reg_wr(mdv_pkg::A_OUT_GAIN, 32'h00009999);
        reg_wr(mdv_pkg::A_CTRL, 32'h00000000);
        reg_wr(mdv_pkg::A_CTRL, C_OUT | 32'h40);
        poll(32'h000CFFFF, 32'h00089999, 400, n);
        reg_wr(mdv_pkg::A_CTRL, C_OUT | 32'h42);
        reg_rd(mdv_pkg::A_STATUS, o);
        `CHK(o[19], 1'b0);
        reg_wr(mdv_pkg::A_CTRL, C_OUT | 32'h40);
        reg_wr(mdv_pkg::A_OUT_GAIN, 32'h0000009D);
        poll(32'h000000FF, 32'h0000009A, 1000, n);
        `CHK(n inside {[127 * FSD:130 * FSD + 8]}, 1);
        poll(32'h0000FFFF, 32'h00009D9D, 200, n);
        reg_wr(mdv_pkg::A_OUT_GAIN, 32'h00000099);
        xfer(16'h0200, 16'h0200, o);
        xfer(16'hFE00, 16'h0200, o);
        poll(32'h0000FFFF, 32'h00009D9C, 60, n);
        xfer(16'hFE00, 16'hFE00, o);
        poll(32'h0000FFFF, 32'h00009999, 60, n);
        reg_wr(mdv_pkg::A_OUT_GAIN, 32'h00000000);
        xfer(16'h0200, 16'h0200, o);
        mute_chk(208);
    endtask : t_out

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        nrst_i = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        stall = 1'b0;
        cyc = 0;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_power();
        t_fifo();
        t_ramp();
        t_link();
        reg_wr(mdv_pkg::A_IN_GAIN, 32'h00000000);
        mute_chk(236);
        t_out();
        results();
    end
endmodule : mdv_volume_tb_top
